// ===== ipm_pkg.sv
package ipm_pkg;
    // SFR addresses
    localparam logic [7:0] PWR_CTRL_ADDR  = 8'h87;
    localparam logic [7:0] PRIO_ONE_ADDR  = 8'hf6;
    localparam logic [7:0] PRIO_TWO_ADDR  = 8'hf7;
    // Reset values
    localparam logic [7:0] PWR_CTRL_RST   = 8'h00;
    localparam logic [7:0] PRIO_ONE_RST   = 8'h00;
    localparam logic [7:0] PRIO_TWO_RST   = 8'h00;
    // Writable bit masks, bit 7 reserved in both priority registers
    localparam logic [7:0] PRIO_ONE_MASK  = 8'h7f;
    localparam logic [7:0] PRIO_TWO_MASK  = 8'h7f;
    // Power control field positions
    localparam int         IDLE_BIT       = 0;
    localparam int         STOP_BIT       = 1;
    // First priority register fields
    localparam int         CMP2_BIT       = 6;
    localparam int         CMP1_BIT       = 5;
    localparam int         CMP0_BIT       = 4;
    localparam int         PCA_BIT        = 3;
    localparam int         ADC0W_BIT      = 2;
    localparam int         SMB_BIT        = 1;
    localparam int         SPI_BIT        = 0;
    // Second priority register fields
    localparam int         UART1_BIT      = 6;
    localparam int         CAN_BIT        = 5;
    localparam int         ADC2C_BIT      = 4;
    localparam int         ADC2W_BIT      = 3;
    localparam int         TMR4_BIT       = 2;
    localparam int         ADC0C_BIT      = 1;
    localparam int         TMR3_BIT       = 0;
    // Restart vector after reset
    localparam logic [15:0] RESET_VECTOR  = 16'h0000;
    // Missing clock detector timeout
    localparam int         DET_TIMEOUT_US = 100;
    localparam int         CLK_MHZ        = 100;
    localparam int         DET_CYCLES     = DET_TIMEOUT_US * CLK_MHZ;
    // Power modes
    typedef enum logic [1:0] {
        IPM_RUN,
        IPM_IDLE,
        IPM_STOP
    } ipm_mode_e;
endpackage

// ===== ipm_sfr_reg.sv
`timescale 1ns/10ps
// Byte register with write mask and synchronous reset
module ipm_sfr_reg #(
    parameter logic [7:0] RST_VAL = 8'h00,
    parameter logic [7:0] WR_MASK = 8'hff
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       wrEn,
    input  wire logic [7:0] wrData,
    output logic      [7:0] q
);
    // Masked write, reserved bits stay zero
    always_ff @(posedge clk) begin
        if (rst) begin
            q <= RST_VAL;
        end else if (wrEn) begin
            q <= wrData & WR_MASK;
        end
    end
endmodule

// ===== ipm_power_prio.sv
`timescale 1ns/10ps
module ipm_power_prio (
    input  wire logic        clk,            // System clock
    input  wire logic        rst,            // Any reset source, watchdog and pin included
    input  wire logic        sfrWe,          // SFR write strobe
    input  wire logic        sfrRe,          // SFR read strobe
    input  wire logic [7:0]  sfrAddr,        // SFR address
    input  wire logic [7:0]  sfrWdata,       // SFR write data
    input  wire logic        instrDone,      // Writing instruction completes
    input  wire logic        irqPending,     // Any enabled interrupt asserted
    input  wire logic        detEnable,      // Missing clock detector enabled
    output logic      [7:0]  sfrRdata,       // SFR read data
    output logic             sfrHit,         // Address decoded by this block
    output logic             cpuClkEn,       // CPU clock gate
    output logic             periphClkEn,    // Timers, interrupts, peripherals clock gate
    output logic             oscEn,          // Internal oscillator enable
    output logic             detRun,         // Missing clock detector running
    output logic             idleWake,       // One-cycle wake pulse to core
    output logic             inIdle,         // Idle mode status
    output logic             inStop,         // Stop mode status
    output logic      [15:0] restartVector,  // Fetch address after reset
    output logic      [6:0]  prioOneBits,    // Priority bits to arbiter
    output logic      [6:0]  prioTwoBits     // Priority bits to arbiter
);
    // State of the block apart from the two priority registers
    typedef struct packed {
        ipm_pkg::ipm_mode_e mode;       // Power mode
        logic               pendIdle;   // Idle requested, waits for instruction end
        logic               pendStop;   // Stop requested, waits for instruction end
        logic [7:0]         rdata;      // Registered read data
        logic               hit;        // Registered decode
        logic               cpuEn;      // CPU clock gate
        logic               perEn;      // Peripheral clock gate
        logic               osc;        // Oscillator enable
        logic               det;        // Detector running
        logic               wake;       // Wake pulse
        logic               idle;       // Idle status flag
        logic               stop;       // Stop status flag
        logic [6:0]         prioOneOut; // Registered first priority bits
        logic [6:0]         prioTwoOut; // Registered second priority bits
        logic [15:0]        vector;     // Registered restart address
    } ipm_state_s;

    ipm_state_s stReg;   // Registered state
    ipm_state_s stNext;  // Next state

    logic [7:0] prioOne;  // First priority register
    logic [7:0] prioTwo;  // Second priority register
    logic       weOne;    // Write strobe first priority
    logic       weTwo;    // Write strobe second priority

    // Address decode, returns 1 on a mapped address
    function automatic logic isMapped(input logic [7:0] a);
        isMapped = (a == ipm_pkg::PWR_CTRL_ADDR) || (a == ipm_pkg::PRIO_ONE_ADDR)
                   || (a == ipm_pkg::PRIO_TWO_ADDR);
    endfunction

    assign weOne = sfrWe && (sfrAddr == ipm_pkg::PRIO_ONE_ADDR);
    assign weTwo = sfrWe && (sfrAddr == ipm_pkg::PRIO_TWO_ADDR);

    // First priority register, bit 7 reserved
    ipm_sfr_reg #(
        .RST_VAL (ipm_pkg::PRIO_ONE_RST),
        .WR_MASK (ipm_pkg::PRIO_ONE_MASK)
    ) uPrioOne (
        .clk    (clk),
        .rst    (rst),
        .wrEn   (weOne),
        .wrData (sfrWdata),
        .q      (prioOne)
    );

    // Second priority register, bit 7 reserved
    ipm_sfr_reg #(
        .RST_VAL (ipm_pkg::PRIO_TWO_RST),
        .WR_MASK (ipm_pkg::PRIO_TWO_MASK)
    ) uPrioTwo (
        .clk    (clk),
        .rst    (rst),
        .wrEn   (weTwo),
        .wrData (sfrWdata),
        .q      (prioTwo)
    );

    // Next-state logic
    always_comb begin
        stNext = stReg;
        stNext.wake = 1'b0;
        // Read path
        stNext.hit = sfrRe && isMapped(sfrAddr);
        stNext.rdata = 8'h00;
        if (sfrRe) begin
            unique case (sfrAddr)
                ipm_pkg::PWR_CTRL_ADDR: begin
                    stNext.rdata = 8'h00;
                end
                ipm_pkg::PRIO_ONE_ADDR: begin
                    stNext.rdata = prioOne;
                end
                ipm_pkg::PRIO_TWO_ADDR: begin
                    stNext.rdata = prioTwo;
                end
                default: begin
                    stNext.rdata = 8'h00;
                end
            endcase
        end
        // Writing one requests a mode, zero is ignored
        if (sfrWe && (sfrAddr == ipm_pkg::PWR_CTRL_ADDR)
            && stReg.mode == ipm_pkg::IPM_RUN) begin
            if (sfrWdata[ipm_pkg::STOP_BIT]) begin
                stNext.pendStop = 1'b1;
            end
            if (sfrWdata[ipm_pkg::IDLE_BIT]) begin
                stNext.pendIdle = 1'b1;
            end
        end
        unique case (stReg.mode)
            ipm_pkg::IPM_RUN: begin
                // Enter at end of the writing instruction, stop has priority
                if (instrDone && (stNext.pendStop || stNext.pendIdle)) begin
                    stNext.mode = stNext.pendStop ? ipm_pkg::IPM_STOP
                                                  : ipm_pkg::IPM_IDLE;
                    stNext.pendStop = 1'b0;
                    stNext.pendIdle = 1'b0;
                end
            end
            ipm_pkg::IPM_IDLE: begin
                // Enabled interrupt clears idle and resumes the CPU
                if (irqPending) begin
                    stNext.mode = ipm_pkg::IPM_RUN;
                    stNext.wake = 1'b1;
                end
            end
            ipm_pkg::IPM_STOP: begin
                // No interrupt leaves stop; only reset does
                stNext.mode = ipm_pkg::IPM_STOP;
            end
            default: begin
                stNext.mode = ipm_pkg::IPM_RUN;
            end
        endcase
        // Clock gates follow the next mode
        stNext.cpuEn = (stNext.mode == ipm_pkg::IPM_RUN);
        stNext.perEn = (stNext.mode != ipm_pkg::IPM_STOP);
        stNext.osc = (stNext.mode != ipm_pkg::IPM_STOP);
        stNext.det = detEnable;
        // Status flags registered so outputs come from flops
        stNext.idle = (stNext.mode == ipm_pkg::IPM_IDLE);
        stNext.stop = (stNext.mode == ipm_pkg::IPM_STOP);
        // Priority bits take the written value on the same edge as the register
        stNext.prioOneOut = weOne ? sfrWdata[6:0] : prioOne[6:0];
        stNext.prioTwoOut = weTwo ? sfrWdata[6:0] : prioTwo[6:0];
        // Restart address is fixed
        stNext.vector = ipm_pkg::RESET_VECTOR;
    end

    // State register, reset ends any mode
    always_ff @(posedge clk) begin
        if (rst) begin
            stReg.mode <= ipm_pkg::IPM_RUN;
            stReg.pendIdle <= 1'b0;
            stReg.pendStop <= 1'b0;
            stReg.rdata <= 8'h00;
            stReg.hit <= 1'b0;
            stReg.cpuEn <= 1'b1;
            stReg.perEn <= 1'b1;
            stReg.osc <= 1'b1;
            stReg.det <= 1'b0;
            stReg.wake <= 1'b0;
            stReg.idle <= 1'b0;
            stReg.stop <= 1'b0;
            stReg.prioOneOut <= ipm_pkg::PRIO_ONE_RST[6:0];
            stReg.prioTwoOut <= ipm_pkg::PRIO_TWO_RST[6:0];
            stReg.vector <= ipm_pkg::RESET_VECTOR;
        end else begin
            stReg <= stNext;
        end
    end

    // Every output is a field of the state register
    assign prioOneBits = stReg.prioOneOut;
    assign prioTwoBits = stReg.prioTwoOut;
    assign restartVector = stReg.vector;
    assign sfrRdata = stReg.rdata;
    assign sfrHit = stReg.hit;
    assign cpuClkEn = stReg.cpuEn;
    assign periphClkEn = stReg.perEn;
    assign oscEn = stReg.osc;
    assign detRun = stReg.det;
    assign idleWake = stReg.wake;
    assign inIdle = stReg.idle;
    assign inStop = stReg.stop;

    // Idle wake within one cycle of interrupt
    property p_idle_wake;
        @(posedge clk) disable iff (rst)
        (stReg.mode == ipm_pkg::IPM_IDLE && irqPending) |=> (idleWake && cpuClkEn);
    endproperty
    a_idle_wake: assert property (p_idle_wake) else $error("idle not left on irq");

    property p_stop_hold;
        @(posedge clk) disable iff (rst)
        inStop |=> inStop && !cpuClkEn && !oscEn;
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("stop left without reset");

    property p_idle_gates;
        @(posedge clk) disable iff (rst)
        inIdle |-> !cpuClkEn && periphClkEn && oscEn;
    endproperty
    a_idle_gates: assert property (p_idle_gates) else $error("idle gating wrong");

    property p_stop_gates;
        @(posedge clk) disable iff (rst)
        inStop |-> !periphClkEn && !oscEn;
    endproperty
    a_stop_gates: assert property (p_stop_gates) else $error("stop gating wrong");

    property p_enter_idle;
        @(posedge clk) disable iff (rst)
        (stReg.mode == ipm_pkg::IPM_RUN && sfrWe && sfrAddr == ipm_pkg::PWR_CTRL_ADDR
         && sfrWdata == 8'h01 && instrDone && !stReg.pendStop) |=> inIdle;
    endproperty
    a_enter_idle: assert property (p_enter_idle) else $error("idle not entered");

    property p_enter_stop;
        @(posedge clk) disable iff (rst)
        (stReg.mode == ipm_pkg::IPM_RUN && sfrWe && sfrAddr == ipm_pkg::PWR_CTRL_ADDR
         && sfrWdata[1] && instrDone) |=> inStop;
    endproperty
    a_enter_stop: assert property (p_enter_stop) else $error("stop not entered");

    property p_ctrl_read;
        @(posedge clk) disable iff (rst)
        (sfrRe && sfrAddr == ipm_pkg::PWR_CTRL_ADDR) |=> (sfrRdata == 8'h00 && sfrHit);
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("mode bits read nonzero");

    // Write, one quiet cycle, then read back the masked byte
    property p_prio_one;
        @(posedge clk) disable iff (rst)
        weOne ##1 !weOne ##1 (!weOne && sfrRe && sfrAddr == ipm_pkg::PRIO_ONE_ADDR)
        |=> sfrRdata == ($past(sfrWdata, 3) & ipm_pkg::PRIO_ONE_MASK);
    endproperty
    a_prio_one: assert property (p_prio_one) else $error("priority one readback");

    property p_prio_two;
        @(posedge clk) disable iff (rst)
        weTwo |=> prioTwoBits == $past(sfrWdata[6:0]);
    endproperty
    a_prio_two: assert property (p_prio_two) else $error("priority two output");

    property p_reset_run;
        @(posedge clk) rst |=> !inStop && !inIdle && cpuClkEn && restartVector == 16'h0000;
    endproperty
    a_reset_run: assert property (p_reset_run) else $error("reset did not end mode");

    // Wake pulse only on leaving idle, with the CPU clock back
    property p_wake_exit;
        @(posedge clk) disable iff (rst)
        idleWake |-> cpuClkEn && !inIdle && $past(inIdle);
    endproperty
    a_wake_exit: assert property (p_wake_exit) else $error("wake without idle");

    // Idle stands while no interrupt arrives
    property p_idle_stay;
        @(posedge clk) disable iff (rst)
        (inIdle && !irqPending) |=> inIdle;
    endproperty
    a_idle_stay: assert property (p_idle_stay) else $error("idle left early");

    // Writing zeros with nothing pending enters no mode
    property p_zero_write;
        @(posedge clk) disable iff (rst)
        (stReg.mode == ipm_pkg::IPM_RUN && sfrWe && sfrAddr == ipm_pkg::PWR_CTRL_ADDR
         && !sfrWdata[ipm_pkg::STOP_BIT] && !sfrWdata[ipm_pkg::IDLE_BIT]
         && !stReg.pendIdle && !stReg.pendStop) |=> !inIdle && !inStop;
    endproperty
    a_zero_write: assert property (p_zero_write) else $error("zero write took effect");

    // Detector status follows its enable one cycle later
    property p_det_follow;
        @(posedge clk) disable iff (rst)
        1'b1 |=> detRun == $past(detEnable);
    endproperty
    a_det_follow: assert property (p_det_follow) else $error("detector status wrong");

    c_idle: cover property (@(posedge clk) disable iff (rst) inIdle ##[1:20] idleWake);
    c_stop: cover property (@(posedge clk) disable iff (rst) inStop);
    c_prio: cover property (@(posedge clk) disable iff (rst) weTwo && sfrWdata[4]);
endmodule

// ===== tb_ipm_power_prio.sv
`timescale 1ns/10ps
// Bench for priority bytes and power modes, driven at the falling edge
module tb_ipm_power_prio;
    logic        clk         = 1'b0;   // System clock
    logic        rst         = 1'b1;   // Sync reset
    logic        sfrWe       = 1'b0;   // Write strobe
    logic        sfrRe       = 1'b0;   // Read strobe
    logic [7:0]  sfrAddr     = 8'h00;  // Address
    logic [7:0]  sfrWdata    = 8'h00;  // Write data
    logic        instrDone   = 1'b0;   // Instruction completes
    logic        irqPending  = 1'b0;   // Enabled interrupt
    logic        detEnable   = 1'b0;   // Detector enable
    logic [7:0]  sfrRdata;             // Read data
    logic        sfrHit;               // Decode hit
    logic        cpuClkEn;             // CPU clock gate
    logic        periphClkEn;          // Peripheral clock gate
    logic        oscEn;                // Oscillator enable
    logic        detRun;               // Detector running
    logic        idleWake;             // Wake pulse
    logic        inIdle;               // Idle status
    logic        inStop;               // Stop status
    logic [15:0] restartVector;        // Restart address
    logic [6:0]  prioOneBits;          // First priority bits
    logic [6:0]  prioTwoBits;          // Second priority bits
    logic [5:0]  modeBits;             // Mode outputs bundled
    int          failures    = 0;      // Mismatch count
    int          n_checks    = 0;      // Comparison count
    int          cycles      = 0;      // Timeout counter
    int          i;                    // Loop index

    // Expected mode bundles: idle, stop, cpu, periph, osc, wake
    localparam logic [5:0] RUN  = 6'h0e;
    localparam logic [5:0] IDLE = 6'h26;
    localparam logic [5:0] STOP = 6'h10;
    localparam logic [5:0] WAKE = 6'h0f;

    assign modeBits = {inIdle, inStop, cpuClkEn, periphClkEn, oscEn, idleWake};

    // Device under test
    ipm_power_prio dut (
        .clk(clk), .rst(rst), .sfrWe(sfrWe), .sfrRe(sfrRe), .sfrAddr(sfrAddr),
        .sfrWdata(sfrWdata), .instrDone(instrDone), .irqPending(irqPending),
        .detEnable(detEnable), .sfrRdata(sfrRdata), .sfrHit(sfrHit), .cpuClkEn(cpuClkEn),
        .periphClkEn(periphClkEn), .oscEn(oscEn), .detRun(detRun), .idleWake(idleWake),
        .inIdle(inIdle), .inStop(inStop), .restartVector(restartVector),
        .prioOneBits(prioOneBits), .prioTwoBits(prioTwoBits)
    );

    // Clock, 10 ns period
    always #5 clk = ~clk;

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            give_verdict();
        end
    end

    // Four-state compare
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Reset held for n cycles
    task automatic do_reset(input int n);
        rst = 1'b1;
        repeat (n) @(negedge clk);
        rst = 1'b0;
    endtask

    // One SFR write, optionally with instruction completion
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic done);
        @(negedge clk);
        sfrWe = 1'b1;
        sfrAddr = a;
        sfrWdata = d;
        instrDone = done;
        @(negedge clk);
        sfrWe = 1'b0;
        instrDone = 1'b0;
    endtask

    // One SFR read, hit flag and data compared
    task automatic rd(input logic [7:0] a, input logic [8:0] exp);
        @(negedge clk);
        sfrRe = 1'b1;
        sfrAddr = a;
        @(negedge clk);
        sfrRe = 1'b0;
        chk(16'({sfrHit, sfrRdata}), 16'(exp));
    endtask

    // Closing report
    task automatic give_verdict();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Main sequence
    initial begin
        do_reset(5);
        chk(16'(modeBits), 16'(RUN));
        chk(restartVector, ipm_pkg::RESET_VECTOR);
        rd(ipm_pkg::PWR_CTRL_ADDR, 9'h100);
        rd(ipm_pkg::PRIO_ONE_ADDR, 9'h100);
        rd(ipm_pkg::PRIO_TWO_ADDR, 9'h100);
        rd(8'h80, 9'h000);
        // Walking one through each priority bit
        for (i = 0; i < 7; i++) begin
            wr(ipm_pkg::PRIO_ONE_ADDR, 8'h01 << i, 1'b0);
            rd(ipm_pkg::PRIO_ONE_ADDR, {1'b1, 8'h01 << i});
            chk(16'(prioOneBits), 16'h0001 << i);
            wr(ipm_pkg::PRIO_TWO_ADDR, 8'h01 << i, 1'b0);
            rd(ipm_pkg::PRIO_TWO_ADDR, {1'b1, 8'h01 << i});
            chk(16'(prioTwoBits), 16'h0001 << i);
        end
        wr(ipm_pkg::PRIO_ONE_ADDR, 8'hff, 1'b0);
        wr(ipm_pkg::PRIO_TWO_ADDR, 8'hff, 1'b0);
        rd(ipm_pkg::PRIO_ONE_ADDR, 9'h17f);
        rd(ipm_pkg::PRIO_TWO_ADDR, 9'h17f);
        // Zero writes change nothing, mode bits stay at RUN
        wr(ipm_pkg::PWR_CTRL_ADDR, 8'h00, 1'b1);
        chk(16'(modeBits), 16'(RUN));
        // Idle request waits for instruction completion, no interrupt meanwhile
        wr(ipm_pkg::PWR_CTRL_ADDR, 8'h01, 1'b0);
        chk(16'(modeBits), 16'(RUN));
        @(negedge clk);
        instrDone = 1'b1;
        @(negedge clk);
        instrDone = 1'b0;
        chk(16'(modeBits), 16'(IDLE));
        chk(16'({prioOneBits, prioTwoBits}), 16'h3fff);
        repeat (3) @(negedge clk);
        chk(16'(modeBits), 16'(IDLE));
        irqPending = 1'b1;
        @(negedge clk);
        irqPending = 1'b0;
        chk(16'(modeBits), 16'(WAKE));
        @(negedge clk);
        chk(16'(modeBits), 16'(RUN));
        rd(ipm_pkg::PWR_CTRL_ADDR, 9'h100);
        // Reset out of idle, as a watchdog overflow would
        wr(ipm_pkg::PWR_CTRL_ADDR, 8'h01, 1'b1);
        chk(16'(modeBits), 16'(IDLE));
        do_reset(1);
        chk(16'(modeBits), 16'(RUN));
        chk(16'({prioOneBits, prioTwoBits}), 16'h0000);
        chk(restartVector, ipm_pkg::RESET_VECTOR);
        // Stop with detector running, both bits set, analog parts taken as off
        detEnable = 1'b1;
        wr(ipm_pkg::PWR_CTRL_ADDR, 8'h03, 1'b1);
        chk(16'(modeBits), 16'(STOP));
        chk(16'(detRun), 16'h0001);
        irqPending = 1'b1;
        repeat (4) @(negedge clk);
        chk(16'(modeBits), 16'(STOP));
        irqPending = 1'b0;
        do_reset(1);
        chk(16'(modeBits), 16'(RUN));
        chk(restartVector, ipm_pkg::RESET_VECTOR);
        @(negedge clk);
        chk(16'(detRun), 16'h0001);
        detEnable = 1'b0;
        @(negedge clk);
        chk(16'(detRun), 16'h0000);
        give_verdict();
    end
endmodule
